// ---- hdl/acrs_map.svh ----
`ifndef ACRS_MAP_SVH
`define ACRS_MAP_SVH
// ---------------------------------------------------------------
// Register map (index; byte address is four times the index)
// ---------------------------------------------------------------
`define ACRS_IDX_MODE        8'h01
`define ACRS_IDX_SETUP0      8'h20
`define ACRS_IDX_STATUS      8'h30
`define ACRS_IDX_SAMPLE      8'h31
`define ACRS_IDX_RESULT      8'h32
`define ACRS_IDX_REFMV       8'h33
`define ACRS_MODE_RESET      16'h2000
`define ACRS_SETUP0_RESET    16'h1000
`define ACRS_REFMV_RESET     16'h09C4
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ACRS_MODE_REF_EN     15
`define ACRS_MODE_CLK_HI     3
`define ACRS_MODE_CLK_LO     2
`define ACRS_SETUP_POL       12
`define ACRS_SETUP_REF_HI    5
`define ACRS_SETUP_REF_LO    4
`define ACRS_SAMPLE_CUR      31
// ---------------------------------------------------------------
// Timing: ref_clk 100 MHz, sources 16 MHz, master 2 MHz
// ---------------------------------------------------------------
`define ACRS_CLK_HZ          100000000
`define ACRS_OSC_HZ          16000000
`define ACRS_MCLK_HZ         2000000
`define ACRS_OSC_DIV         (`ACRS_CLK_HZ / `ACRS_OSC_HZ)
`define ACRS_MCLK_DIV        (`ACRS_OSC_HZ / `ACRS_MCLK_HZ)
`endif

// ---- hdl/acrs_pkg.sv ----
package acrs_pkg;
    // Clock source selection codes
    typedef enum logic [1:0] {
        ACRS_CLK_INT    = 2'h0,
        ACRS_CLK_INTOUT = 2'h1,
        ACRS_CLK_EXT    = 2'h2,
        ACRS_CLK_XTAL   = 2'h3
    } acrs_clksel_t;
    // Reference source selection codes
    typedef enum logic [1:0] {
        ACRS_REF_EXT  = 2'h0,
        ACRS_REF_INT  = 2'h2,
        ACRS_REF_AVDD = 2'h3
    } acrs_refsel_t;
    // Wishbone request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [9:0]  adr;
        logic [31:0] dat;
    } acrs_wb_req_t;
    // Clock pin output in two signals
    typedef struct packed {
        logic o;
        logic oe;
    } acrs_pin_t;
endpackage

// ---- hdl/acrs_top.sv ----
`timescale 1ns/1ns
`include "acrs_map.svh"
module acrs_top (
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire acrs_pkg::acrs_wb_req_t wb_req,
    output logic [31:0]             wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic               crystal_input_pin,
    input  wire logic               crystal_or_clock_io_pin_i,
    output logic                    crystal_or_clock_io_pin_o,
    output logic                    crystal_or_clock_io_pin_oe,
    output logic                    reference_output_pin_en,
    output logic [1:0]              reference_source_select,
    output logic                    mclk_en,
    output logic                    odr_en
);
    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [15:0] mode_r;
    logic [15:0] setup0_r;
    logic [15:0] refmv_r;
    logic [31:0] sample_r;
    logic [23:0] result_r;
    logic [23:0] result_nxt;
    logic        ack_r;
    logic [31:0] rdat_r;
    logic [2:0]  osc_cnt_r;
    logic [2:0]  mdiv_cnt_r;
    logic        osc_en;
    logic        src_en;
    logic        xtal_d_r;
    logic        ext_d_r;
    logic [7:0]  odr_cnt_r;
    logic        wr_stb;
    logic [7:0]  idx;
    acrs_pkg::acrs_clksel_t clksel;

    assign idx    = wb_req.adr[9:2];
    assign wr_stb = wb_req.cyc & wb_req.stb & wb_req.we & ~ack_r;
    assign clksel = acrs_pkg::acrs_clksel_t'(
        mode_r[`ACRS_MODE_CLK_HI:`ACRS_MODE_CLK_LO]);

    // ---------------------------------------------------------------
    // Bus slave
    // ---------------------------------------------------------------
    // Ack one cycle after strobe, dropped the cycle after
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_req.cyc & wb_req.stb & ~ack_r;
        end
    end
    assign wb_ack_o = ack_r;

    // Register writes with byte lanes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_r   <= `ACRS_MODE_RESET;
            setup0_r <= `ACRS_SETUP0_RESET;
            refmv_r  <= `ACRS_REFMV_RESET;
            sample_r <= 32'h0000_0000;
        end else if (wr_stb) begin
            case (idx)
                `ACRS_IDX_MODE: begin
                    if (wb_req.sel[0]) mode_r[7:0]  <= wb_req.dat[7:0];
                    if (wb_req.sel[1]) mode_r[15:8] <= wb_req.dat[15:8];
                end
                `ACRS_IDX_SETUP0: begin
                    if (wb_req.sel[0]) setup0_r[7:0] <= wb_req.dat[7:0];
                    if (wb_req.sel[1]) setup0_r[15:8] <= wb_req.dat[15:8];
                end
                `ACRS_IDX_REFMV: begin
                    if (wb_req.sel[0]) refmv_r[7:0]  <= wb_req.dat[7:0];
                    if (wb_req.sel[1]) refmv_r[15:8] <= wb_req.dat[15:8];
                end
                `ACRS_IDX_SAMPLE: begin
                    if (wb_req.sel[0]) sample_r[7:0] <= wb_req.dat[7:0];
                    if (wb_req.sel[1]) sample_r[15:8] <= wb_req.dat[15:8];
                    if (wb_req.sel[2]) sample_r[23:16] <= wb_req.dat[23:16];
                    if (wb_req.sel[3]) sample_r[31:24] <= wb_req.dat[31:24];
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdat_r <= 32'h0000_0000;
        end else begin
            case (idx)
                `ACRS_IDX_MODE:   rdat_r <= {16'h0000, mode_r};
                `ACRS_IDX_SETUP0: rdat_r <= {16'h0000, setup0_r};
                `ACRS_IDX_REFMV:  rdat_r <= {16'h0000, refmv_r};
                `ACRS_IDX_SAMPLE: rdat_r <= sample_r;
                `ACRS_IDX_RESULT: rdat_r <= {8'h00, result_r};
                `ACRS_IDX_STATUS: rdat_r <= {26'h0, odr_cnt_r[0],
                    crystal_or_clock_io_pin_oe, reference_output_pin_en,
                    reference_source_select, mclk_en};
                default:          rdat_r <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_dat_o = rdat_r;

    // ---------------------------------------------------------------
    // Reference control
    // ---------------------------------------------------------------
    // Reference pin driven only when enable bit set
    assign reference_output_pin_en = mode_r[`ACRS_MODE_REF_EN];
    assign reference_source_select =
        setup0_r[`ACRS_SETUP_REF_HI:`ACRS_SETUP_REF_LO];

    // ---------------------------------------------------------------
    // Master clock generation
    // ---------------------------------------------------------------
    // Internal 16 MHz oscillator model: enable every six ref cycles
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            osc_cnt_r <= 3'h0;
        end else if (osc_cnt_r == 3'(`ACRS_OSC_DIV - 1)) begin
            osc_cnt_r <= 3'h0;
        end else begin
            osc_cnt_r <= osc_cnt_r + 3'h1;
        end
    end
    assign osc_en = (osc_cnt_r == 3'h0);

    // Edge detect of crystal and external clock inputs
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            xtal_d_r <= 1'b0;
            ext_d_r  <= 1'b0;
        end else begin
            xtal_d_r <= crystal_input_pin;
            ext_d_r  <= crystal_or_clock_io_pin_i;
        end
    end

    // Source mux; external clock goes straight to modulator
    always_comb begin
        case (clksel)
            acrs_pkg::ACRS_CLK_XTAL:
                src_en = crystal_input_pin & ~xtal_d_r;
            acrs_pkg::ACRS_CLK_EXT:
                src_en = 1'b0;
            default:
                src_en = osc_en;
        endcase
    end

    // Divide 16 MHz source by eight to 2 MHz
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mdiv_cnt_r <= 3'h0;
        end else if (src_en) begin
            mdiv_cnt_r <= mdiv_cnt_r + 3'h1;
        end
    end
    assign mclk_en = (clksel == acrs_pkg::ACRS_CLK_EXT) ?
        (crystal_or_clock_io_pin_i & ~ext_d_r) :
        (src_en && mdiv_cnt_r == 3'(`ACRS_MCLK_DIV - 1));

    // Output data rate tick derived from master clock only
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            odr_cnt_r <= 8'h00;
        end else if (mclk_en) begin
            odr_cnt_r <= odr_cnt_r + 8'h01;
        end
    end
    assign odr_en = mclk_en & (odr_cnt_r == 8'hFF);

    // Oscillator out on clock pin; pin is input otherwise
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            crystal_or_clock_io_pin_o  <= 1'b0;
            crystal_or_clock_io_pin_oe <= 1'b0;
        end else begin
            crystal_or_clock_io_pin_oe <=
                (clksel == acrs_pkg::ACRS_CLK_INTOUT);
            if (osc_en) begin
                crystal_or_clock_io_pin_o <= ~crystal_or_clock_io_pin_o;
            end
        end
    end

    // ---------------------------------------------------------------
    // Output coding
    // ---------------------------------------------------------------
    // sample_r[30:0] signed input in tenths of microvolts, or in microamps when bit 31 is set
    always_comb begin
        logic signed [31:0] in_v;
        logic signed [63:0] num;
        logic signed [63:0] code;
        logic signed [63:0] den;
        num  = 64'sd0;
        code = 64'sd0;
        in_v = $signed({sample_r[30], sample_r[30:0]});
        den  = $signed({48'h0, refmv_r}) * 64'sd1000;
        // Current term: uA*50 ohm equals scaled voltage (0.1*uV)
        if (sample_r[`ACRS_SAMPLE_CUR]) begin
            num = 64'(in_v) * 64'sd50 * 64'sd10;
        end else begin
            num = 64'(in_v);
        end
        if (den == 64'sd0) begin
            code = 64'sd0;
        end else if (setup0_r[`ACRS_SETUP_POL]) begin
            // den is in microvolts and num in tenths, so the 838861 factor also carries the divide by ten
            code = 64'sd8388608 + (num * 64'sd838861) / den;
        end else begin
            code = (num * 64'sd1677722) / den;
        end
        // Clamp to code range
        if (code < 64'sd0) begin
            result_nxt = 24'h000000;
        end else if (code > 64'sd16777215) begin
            result_nxt = 24'hFFFFFF;
        end else begin
            result_nxt = code[23:0];
        end
    end

    // Result captured at each output data tick
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            result_r <= 24'h000000;
        end else if (odr_en) begin
            result_r <= result_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_ref_pin_en: assert property (@(posedge ref_clk) disable iff (!resetn)
        reference_output_pin_en == mode_r[15])
        else $error("reference pin enable mismatch");
    a_ref_sel: assert property (@(posedge ref_clk) disable iff (!resetn)
        reference_source_select == setup0_r[5:4])
        else $error("reference select mismatch");
    a_mclk_rate: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clksel == acrs_pkg::ACRS_CLK_INT && mclk_en) ##1
        (clksel == acrs_pkg::ACRS_CLK_INT) [*8] |-> !mclk_en)
        else $error("master clock faster than 2 MHz");
    a_osc_period: assert property (@(posedge ref_clk) disable iff (!resetn)
        osc_en |=> !osc_en [*5] ##1 osc_en)
        else $error("oscillator period not six cycles");
    a_pin_out: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clksel == acrs_pkg::ACRS_CLK_INTOUT) |=> crystal_or_clock_io_pin_oe)
        else $error("clock pin not driven");
    a_pin_in: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clksel == acrs_pkg::ACRS_CLK_EXT) |=> !crystal_or_clock_io_pin_oe)
        else $error("clock pin driven while input");
    a_ext_route: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clksel == acrs_pkg::ACRS_CLK_EXT && !ext_d_r &&
         crystal_or_clock_io_pin_i) |-> mclk_en)
        else $error("external clock edge not routed");
    a_odr_scale: assert property (@(posedge ref_clk) disable iff (!resetn)
        odr_en |-> mclk_en)
        else $error("data tick without master clock");
    a_bip_mid: assert property (@(posedge ref_clk) disable iff (!resetn)
        (setup0_r[12] && sample_r[30:0] == 31'h0 && refmv_r != 16'h0)
        |-> result_nxt == 24'h800000)
        else $error("bipolar zero not midscale");
    a_uni_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!setup0_r[12] && sample_r[30]) |-> result_nxt == 24'h000000)
        else $error("unipolar negative not saturated");
    a_bus_ack: assert property (@(posedge ref_clk) disable iff (!resetn)
        ack_r |=> !ack_r)
        else $error("ack held two cycles");
endmodule

// ---- tb/acrs_clk_src.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Crystal or external clock source at the far side of the pins
// ---------------------------------------------------------------
module acrs_clk_src #(
    parameter int START = 16
) (
    input  wire logic       ref_clk,
    input  wire logic       run,
    input  wire logic [3:0] half,
    output logic            clk_o
);
    int cnt;
    initial clk_o = 1'b0;
    // Stands still while stopped; quiet startup span, then toggles
    always @(posedge ref_clk) begin
        if (!run) begin
            cnt   <= 0;
            clk_o <= 1'b0;
        end else if (cnt < START + half - 1) begin
            cnt <= cnt + 1;
        end else begin
            cnt   <= START;
            clk_o <= ~clk_o;
        end
    end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    logic                   ref_clk, resetn, wb_ack_o, xtal, ext_clk;
    logic                   pin_w, pin_o, pin_oe, ref_en, mclk_en, odr_en;
    logic                   xt_run, ex_run;
    logic [1:0]             ref_sel;
    logic [31:0]            wb_dat_o, rd;
    acrs_pkg::acrs_wb_req_t wb_req;
    int                     num_errors, cmp_count, c;
    logic [1:0]             refc [3] = '{2'h2, 2'h3, 2'h0};
    int                     expc [4] = '{20, 20, 240, 15};
    logic [31:0]            smp [10] = '{32'h0, 32'h00BEBC20, 32'h017D7840,
        32'h01C9C380, 32'h80004E20, 32'h0, 32'h7E8287C0, 32'h00BEBC20,
        32'h7E363C80, 32'h80002710};
    logic [31:0]            exr [10] = '{32'h0, 32'h800000, 32'hFFFFFF,
        32'hFFFFFF, 32'h666666, 32'h800000, 32'h0, 32'hC00000, 32'h0,
        32'h999999};
    // Wire level of the shared clock pin
    assign pin_w = pin_oe ? pin_o : ext_clk;
    acrs_top dut (.ref_clk(ref_clk), .resetn(resetn), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .crystal_input_pin(xtal),
        .crystal_or_clock_io_pin_i(pin_w), .crystal_or_clock_io_pin_o(pin_o),
        .crystal_or_clock_io_pin_oe(pin_oe), .reference_output_pin_en(ref_en),
        .reference_source_select(ref_sel), .mclk_en(mclk_en),
        .odr_en(odr_en));
    acrs_clk_src u_xt (.ref_clk(ref_clk), .run(xt_run), .half(4'h4),
        .clk_o(xtal));
    acrs_clk_src u_ex (.ref_clk(ref_clk), .run(ex_run), .half(4'h2),
        .clk_o(ext_clk));
    // Classic single Wishbone cycle, waits for ack
    task automatic wb_cyc(input logic we, input logic [9:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        if (n >= 20) num_errors++;
        wb_req <= '0;
        @(posedge ref_clk);
    endtask
    // Compare within a tolerance; tolerance 0 is exact
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g, input int tol);
        cmp_count++;
        if ($isunknown(g) || g > e + tol || g + tol < e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Master clock pulses over a span of cycles
    task automatic cnt_mclk(input int n, output int k);
        k = 0;
        repeat (n) begin
            @(posedge ref_clk);
            if (mclk_en === 1'b1) k++;
        end
    endtask
    // Cycles until the next data tick, bounded
    task automatic wait_odr(output int k);
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (odr_en !== 1'b1 && k < 5000);
        if (k >= 5000) num_errors++;
    endtask
    task automatic results;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Watchdog
    initial begin
        #(60000 * 10);
        num_errors++;
        results();
    end
    // Test sequence
    initial begin
        resetn = 1'b0;
        wb_req = '0;
        xt_run = 1'b0;
        ex_run = 1'b0;
        num_errors = 0;
        cmp_count = 0;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        chk("ref_en", 0, ref_en, 0);
        chk("ref_sel", 0, ref_sel, 0);
        wb_cyc(0, 10'h004, 0, rd);
        chk("mode", 32'h2000, rd, 0);
        wb_cyc(0, 10'h080, 0, rd);
        chk("setup0", 32'h1000, rd, 0);
        wb_cyc(1, 10'h3F0, 32'hFFFF, rd);
        wb_cyc(0, 10'h3F0, 0, rd);
        chk("unmapped", 0, rd, 0);
        $display("done reset");
        foreach (refc[i]) begin
            wb_cyc(1, 10'h080, {26'h0, refc[i], 4'h0}, rd);
            chk("ref_sel", refc[i], ref_sel, 0);
        end
        wb_cyc(1, 10'h004, 32'hA000, rd);
        chk("ref_en", 1, ref_en, 0);
        wb_cyc(1, 10'h004, 32'h2000, rd);
        chk("ref_en", 0, ref_en, 0);
        $display("done reference");
        for (int s = 0; s < 4; s++) begin
            xt_run <= (s == 3);
            ex_run <= (s == 2);
            wb_cyc(1, 10'h004, 32'h2000 | (s << 2), rd);
            repeat (40) @(posedge ref_clk);
            chk("pin_oe", s == 1, pin_oe, 0);
            cnt_mclk(960, c);
            chk("mclk", expc[s], c, 1);
        end
        xt_run <= 1'b0;
        ex_run <= 1'b1;
        wb_cyc(1, 10'h004, 32'h2008, rd);
        wait_odr(c);
        wait_odr(c);
        chk("odr_gap", 1024, c, 1);
        $display("done clock");
        foreach (smp[i]) begin
            wb_cyc(1, 10'h080, (i < 5) ? 32'h0 : 32'h1000, rd);
            wb_cyc(1, 10'h0C4, smp[i], rd);
            wait_odr(c);
            wait_odr(c);
            wb_cyc(0, 10'h0C8, 0, rd);
            chk("code", exr[i], rd, 2);
        end
        $display("done coding");
        results();
    end
endmodule
